// File: bench/stl_host_model.sv
// Host model: writes the selective log and captures streamed sectors
`timescale 1ns/1ps
module stl_host_model (
    input  wire logic       mclk_in,
    input  wire logic       rd_valid_in,
    input  wire logic       rd_last_in,
    input  wire logic [7:0] rd_data_in,
    output logic            wr_start_out,
    output logic            wr_valid_out,
    output logic      [7:0] wr_data_out
);
    logic [7:0] sec [512];
    int         idx      = 0;
    int         done_cnt = 0;
    int         last_len = 0;

    initial begin
        wr_start_out = 1'b0;
        wr_valid_out = 1'b0;
        wr_data_out  = 8'hA5;
    end

    // Bytes kept in stream order; a sector closes on its last byte
    always @(posedge mclk_in) begin
        if (rd_valid_in) begin
            if (idx < 512) sec[idx] = rd_data_in;
            idx++;
            if (rd_last_in) begin
                last_len = idx;
                idx      = 0;
                done_cnt++;
            end
        end
    end

    // Host picks test parameters by writing the whole sector
    task automatic write_sector();
        @(negedge mclk_in);
        wr_start_out = 1'b1;
        for (int i = 0; i < 512; i++) begin
            @(negedge mclk_in);
            wr_start_out = 1'b0;
            wr_valid_out = 1'b1;
            wr_data_out  = 8'(i) ^ 8'h5A;
        end
        @(negedge mclk_in);
        wr_valid_out = 1'b0;
        wr_data_out  = ~wr_data_out; // Released line: stale value must not be trusted
    endtask
endmodule

// File: bench/stl_keeper_props.sv
// Concurrent checks on the record and read ports of the log keeper
`timescale 1ns/1ps
module stl_keeper_props (
    input  wire logic       mclk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       rec_valid_in,
    input  wire logic       rd_start_in,
    input  logic      [7:0] ptr_out,
    input  logic            rd_valid_out,
    input  logic            rd_last_out,
    input  logic      [7:0] rd_data_out,
    input  logic            busy_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    // ------------------------------------------------------------
    // Stream byte counter, wraps after a whole sector
    // ------------------------------------------------------------
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    always_comb begin
        cnt_next = cnt_reg;
        if (rd_valid_out) begin
            cnt_next = cnt_reg + 9'h001;
        end
    end
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_reg <= 9'h000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Read acceptance and the start of the byte stream
    sequence accept_s;
        rd_start_in && !busy_out;
    endsequence
    sequence stream_s;
        busy_out ##1 rd_valid_out;
    endsequence

    start_stream_a: assert property (accept_s |=> stream_s)
        else $error("read start not followed by stream");
    last_count_a: assert property (rd_valid_out |-> (rd_last_out == (cnt_reg == 9'h1FF)))
        else $error("last byte not at byte 511");
    stream_run_a: assert property (rd_valid_out && !rd_last_out |=> rd_valid_out)
        else $error("gap inside sector stream");
    last_done_a: assert property (rd_last_out |-> rd_valid_out && !busy_out)
        else $error("last byte without valid or with busy");
    busy_stream_a: assert property (rd_valid_out && !rd_last_out |-> busy_out)
        else $error("busy low during stream");
    idle_data_a: assert property (!rd_valid_out |-> rd_data_out == 8'h00)
        else $error("read data not zero when idle");
    ptr_range_a: assert property (ptr_out <= 8'h15)
        else $error("pointer out of range");
    ptr_step_a: assert property (rec_valid_in |=>
        ptr_out == (($past(ptr_out) == 8'h15) ? 8'h01 : $past(ptr_out) + 8'h01))
        else $error("pointer did not advance or wrap");
    ptr_hold_a: assert property (!rec_valid_in |=> $stable(ptr_out))
        else $error("pointer moved without record");
endmodule

bind stl_log_keeper stl_keeper_props u_props (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .rec_valid_in(rec_valid_in), .rd_start_in(rd_start_in),
    .ptr_out(ptr_out), .rd_valid_out(rd_valid_out), .rd_last_out(rd_last_out), .rd_data_out(rd_data_out),
    .busy_out(busy_out)
);

// File: bench/stl_log_keeper_bench.sv
// Self-checking bench for the self-test log keeper
`timescale 1ns/1ps
module stl_log_keeper_bench import stl_pkg::*;;
    logic        mclk_in      = 1'b0;
    logic        sys_rst_in   = 1'b1;
    logic        rec_valid_in = 1'b0;
    stl_desc_s   rec_desc_in  = '0;
    logic        rd_start_in  = 1'b0;
    stl_log_e    rd_log_in    = STL_LOG_SELFTEST;
    logic [63:0] prog_lba_in  = 64'h0123_4567_89AB_CDEF;
    logic [15:0] prog_span_in = 16'hBEEF;
    logic        wr_start_in;
    logic        wr_valid_in;
    logic [7:0]  wr_data_in;
    logic [7:0]  ptr_out;
    logic [7:0]  rd_data_out;
    logic        rd_valid_out;
    logic        rd_last_out;
    logic        busy_out;
    int          bad_count    = 0;
    int          n_tests      = 0;
    stl_desc_s   slot [21]    = '{default: '0};
    logic [7:0]  ptr_exp      = 8'h00;
    logic [7:0]  exp_sec [512];

    always #25 mclk_in = ~mclk_in;

    stl_log_keeper dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .rec_valid_in(rec_valid_in),
        .rec_desc_in(rec_desc_in), .rd_start_in(rd_start_in), .rd_log_in(rd_log_in), .wr_start_in(wr_start_in),
        .wr_valid_in(wr_valid_in), .wr_data_in(wr_data_in), .prog_lba_in(prog_lba_in),
        .prog_span_in(prog_span_in), .ptr_out(ptr_out), .rd_valid_out(rd_valid_out), .rd_last_out(rd_last_out),
        .rd_data_out(rd_data_out), .busy_out(busy_out));
    stl_host_model host (.mclk_in(mclk_in), .rd_valid_in(rd_valid_out), .rd_last_in(rd_last_out),
        .rd_data_in(rd_data_out), .wr_start_out(wr_start_in), .wr_valid_out(wr_valid_in), .wr_data_out(wr_data_in));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
        n_tests++;
        if (got !== want) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    // Back-to-back records, rec_valid held high between them
    task automatic records(input int k0, input int n);
        stl_desc_s d;
        for (int k = k0; k < k0 + n; k++) begin
            d = '{8'(k), ~8'(k), 16'hA500 | 16'(k), 8'(k) ^ 8'h3C, 32'h1234_5600 | 32'(k)};
            @(negedge mclk_in);
            rec_valid_in = 1'b1;
            rec_desc_in  = d;
            ptr_exp      = (ptr_exp == 8'h15) ? 8'h01 : ptr_exp + 8'h01;
            slot[ptr_exp - 8'h01] = d;
        end
        @(negedge mclk_in);
        rec_valid_in = 1'b0;
    endtask

    // Checksum closes the expected sector
    task automatic close_sum();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 511; i++) s += exp_sec[i];
        exp_sec[511] = 8'h00 - s;
    endtask

    // Expected self-test log, fields least significant byte first
    task automatic build_st();
        int b;
        exp_sec = '{default: 8'h00};
        exp_sec[0] = REV_RESET[7:0];
        exp_sec[1] = REV_RESET[15:8];
        for (int n = 0; n < 21; n++) begin
            b = 2 + 24 * n;
            exp_sec[b] = slot[n].test_num;
            exp_sec[b + 1] = slot[n].status;
            exp_sec[b + 2] = slot[n].poh[7:0];
            exp_sec[b + 3] = slot[n].poh[15:8];
            exp_sec[b + 4] = slot[n].checkpoint;
            for (int j = 0; j < 4; j++) exp_sec[b + 5 + j] = slot[n].fail_lba[8 * j +: 8];
        end
        exp_sec[9'h1FC] = ptr_exp;
        close_sum();
    endtask

    // Read one sector, poke a refused start mid-stream, compare all bytes
    task automatic read_sector(input stl_log_e log);
        int         d0;
        logic [7:0] s;
        d0 = host.done_cnt;
        @(negedge mclk_in);
        rd_start_in = 1'b1;
        rd_log_in   = log;
        @(negedge mclk_in);
        rd_start_in = 1'b0;
        repeat (100) @(negedge mclk_in);
        chk(16'(busy_out), 16'h0001, "busy mid read");
        // Refused start names the other log: taking it would corrupt the stream
        rd_start_in = 1'b1;
        rd_log_in   = (log == STL_LOG_SELFTEST) ? STL_LOG_SELECTIVE : STL_LOG_SELFTEST;
        @(negedge mclk_in);
        rd_start_in = 1'b0;
        rd_log_in   = log;
        for (int i = 0; i < 700 && host.done_cnt == d0; i++) @(negedge mclk_in);
        if (host.done_cnt == d0) begin
            chk(16'h0000, 16'h0001, "read timeout");
            conclude();
        end
        chk(16'(host.last_len), 16'h0200, "sector length");
        s = 8'h00;
        for (int i = 0; i < 512; i++) s += host.sec[i];
        chk(16'(s), 16'h0000, "sector sum");
        for (int i = 0; i < 512; i++) chk(16'(host.sec[i]), 16'(exp_sec[i]), "sector byte");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_empty();
        chk(16'(ptr_out), 16'h0000, "empty pointer");
        build_st();
        read_sector(STL_LOG_SELFTEST);
    endtask

    task automatic t_ring();
        records(1, 1);
        chk(16'(ptr_out), 16'h0001, "first pointer");
        build_st();
        read_sector(STL_LOG_SELFTEST);
        chk(16'(host.sec[9'h00A]), 16'h0012, "lba top byte");
        records(2, 20);
        chk(16'(ptr_out), 16'h0015, "full pointer");
        build_st();
        read_sector(STL_LOG_SELFTEST);
        chk(16'(host.sec[9'h1E2]), 16'h0015, "slot 20 number");
        records(22, 1);
        chk(16'(ptr_out), 16'h0001, "wrapped pointer");
        build_st();
        read_sector(STL_LOG_SELFTEST);
        chk(16'(host.sec[9'h002]), 16'h0016, "oldest replaced");
    endtask

    task automatic t_sel();
        host.write_sector();
        for (int i = 0; i < 512; i++) exp_sec[i] = (i >= 9'h052 && i < 9'h152) ? 8'h00 : 8'(i) ^ 8'h5A;
        for (int j = 0; j < 8; j++) exp_sec[9'h1EC + j] = prog_lba_in[8 * j +: 8];
        exp_sec[9'h1F4] = prog_span_in[7:0];
        exp_sec[9'h1F5] = prog_span_in[15:8];
        close_sum();
        read_sector(STL_LOG_SELECTIVE);
        chk(16'(host.sec[9'h051]), 16'h000B, "host field readback");
        chk(16'(host.sec[9'h1EC]), 16'h00EF, "progress lba low");
    endtask

    initial begin
        repeat (5) @(negedge mclk_in);
        sys_rst_in = 1'b0;
        t_empty();
        t_ring();
        t_sel();
        conclude();
    end
endmodule

// File: inc/stl_pkg.sv
// Shared constants and types for the self-test log keeper
package stl_pkg;

    // ------------------------------------------------------------
    // Sector geometry
    // ------------------------------------------------------------
    localparam int          SECTOR_BYTES = 512;
    localparam logic [8:0]  CSUM_OFF     = 9'h1FF;  // Last byte, checksum
    localparam logic [8:0]  LAST_IDX     = 9'h1FF;

    // ------------------------------------------------------------
    // Self-test log layout
    // ------------------------------------------------------------
    localparam int          DESC_SLOTS   = 21;
    localparam logic [8:0]  REV_OFF      = 9'h000;  // Two-byte revision word
    localparam logic [8:0]  DESC_BASE    = 9'h002;  // Descriptor n at n*18h+02h
    localparam logic [8:0]  DESC_BYTES   = 9'h018;  // 24 bytes per descriptor
    localparam logic [8:0]  PTR_OFF      = 9'h1FC;  // Most recent descriptor
    localparam logic [15:0] REV_RESET    = 16'h0001;
    localparam logic [7:0]  PTR_EMPTY    = 8'h00;

    // Byte positions inside one descriptor (relative to its start)
    localparam logic [4:0]  D_NUM_OFF    = 5'h00;  // Test number
    localparam logic [4:0]  D_STAT_OFF   = 5'h01;  // Execution status
    localparam logic [4:0]  D_POH_OFF    = 5'h02;  // Power-on hours, 2 bytes
    localparam logic [4:0]  D_CHK_OFF    = 5'h04;  // Failure checkpoint
    localparam logic [4:0]  D_LBA_OFF    = 5'h05;  // First failing LBA, 4 bytes
    localparam logic [4:0]  D_VEND_OFF   = 5'h09;  // 15 vendor bytes, read zero

    // ------------------------------------------------------------
    // Selective self-test log layout
    // ------------------------------------------------------------
    localparam logic [8:0]  SEL_RSV_OFF  = 9'h052;  // 256 reserved bytes
    localparam logic [8:0]  SEL_RSV_END  = 9'h152;
    localparam logic [8:0]  SEL_LBA_OFF  = 9'h1EC;  // Current LBA, 8 bytes
    localparam logic [8:0]  SEL_SPAN_OFF = 9'h1F4;  // Current span, 2 bytes
    localparam logic [8:0]  SEL_SPAN_END = 9'h1F6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        STL_LOG_SELFTEST  = 1'b0,
        STL_LOG_SELECTIVE = 1'b1
    } stl_log_e;

    typedef enum logic [1:0] {
        STL_ST_IDLE   = 2'b00,
        STL_ST_STREAM = 2'b01,
        STL_ST_CSUM   = 2'b11
    } stl_state_e;

    typedef struct packed {
        logic [7:0]  test_num;
        logic [7:0]  status;
        logic [15:0] poh;
        logic [7:0]  checkpoint;
        logic [31:0] fail_lba;
    } stl_desc_s;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } stl_byte_s;

endpackage

// File: src/stl_log_keeper.sv
// Self-test log and selective self-test log sector keeper
//
// Function
// [RULE1] Self-test log: 512-byte sector, revision at 00h
// [RULE2] Descriptors 24 bytes at n*18h+02h, n=0..20
// [RULE3] Descriptor field offsets fixed within each slot
// [RULE4] At most 21 descriptors held
// [RULE5] Full ring overwrites the oldest descriptor
// [RULE6] Pointer byte at 1FCh names newest descriptor
// [RULE7] Pointer zero when empty, else 1..21
// [RULE8] Multi-byte fields stored least significant first
// [RULE9] Last byte makes sector sum zero
// [RULE10] Selective log is host writable and readable
// [RULE11] Host sets parameters, device reports progress there
// [RULE12] Selective layout: host fields to 51h, reserved 52h..151h
// [RULE13] Record advances pointer, wraps 21 to 1
`timescale 1ns/1ps
module stl_log_keeper import stl_pkg::*; #(
    parameter logic [15:0] REVISION = REV_RESET,
    parameter int          SLOTS    = DESC_SLOTS
) (
    input  wire logic        mclk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        rec_valid_in,
    input  stl_desc_s        rec_desc_in,
    input  wire logic        rd_start_in,
    input  stl_log_e         rd_log_in,
    input  wire logic        wr_start_in,
    input  wire logic        wr_valid_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic [63:0] prog_lba_in,
    input  wire logic [15:0] prog_span_in,
    output logic      [7:0]  ptr_out,
    output logic             rd_valid_out,
    output logic             rd_last_out,
    output logic      [7:0]  rd_data_out,
    output logic             busy_out
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------

    // Byte k of a little-endian value
    function automatic logic [7:0] pick_byte(input logic [63:0] v, input logic [2:0] k);
        pick_byte = v[8*k +: 8];  // [RULE8]
    endfunction

    // Byte at offset off within one stored descriptor
    function automatic logic [7:0] desc_byte(input stl_desc_s d, input logic [4:0] off);
        logic [4:0] rel;
        rel       = 5'h00;
        desc_byte = 8'h00;  // Vendor bytes read as zero
        if (off == D_NUM_OFF) begin
            desc_byte = d.test_num;  // [RULE3]
        end else if (off == D_STAT_OFF) begin
            desc_byte = d.status;  // [RULE3]
        end else if (off < D_CHK_OFF && off >= D_POH_OFF) begin
            rel       = 5'(off - D_POH_OFF);
            desc_byte = pick_byte({48'h0, d.poh}, rel[2:0]);  // [RULE3]
        end else if (off == D_CHK_OFF) begin
            desc_byte = d.checkpoint;  // [RULE3]
        end else if (off < D_VEND_OFF && off >= D_LBA_OFF) begin
            rel       = 5'(off - D_LBA_OFF);
            desc_byte = pick_byte({32'h0, d.fail_lba}, rel[2:0]);  // [RULE3]
        end
    endfunction

    // ------------------------------------------------------------
    // Descriptor ring and pointer
    // ------------------------------------------------------------
    localparam logic [7:0] SLOTS_W = 8'(SLOTS);

    stl_desc_s  slot_reg  [SLOTS];
    stl_desc_s  slot_next [SLOTS];
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;

    // Pointer steps 0->1..21->1; the slot it lands on is the oldest once full
    always_comb begin
        ptr_next = ptr_reg;
        for (int i = 0; i < SLOTS; i++) begin
            slot_next[i] = slot_reg[i];
        end
        if (rec_valid_in) begin
            if (ptr_reg >= SLOTS_W) begin
                ptr_next = 8'h01;  // [RULE13] [RULE5] [RULE7]
            end else begin
                ptr_next = 8'(ptr_reg + 8'h01);  // [RULE13]
            end
            for (int i = 0; i < SLOTS; i++) begin
                if (8'(i + 1) == ptr_next) begin
                    slot_next[i] = rec_desc_in;  // [RULE4] [RULE5]
                end
            end
        end
    end

    // Ring storage is reset so unused slots read as zero
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ptr_reg <= PTR_EMPTY;  // [RULE7]
            for (int i = 0; i < SLOTS; i++) begin
                slot_reg[i] <= '0;
            end
        end else begin
            ptr_reg <= ptr_next;
            for (int i = 0; i < SLOTS; i++) begin
                slot_reg[i] <= slot_next[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Selective log storage, written by the host byte by byte
    // ------------------------------------------------------------
    logic [7:0] sel_mem [SECTOR_BYTES];
    logic [8:0] wr_idx_reg;
    logic [8:0] wr_idx_next;

    // Write cursor restarts on each sector write start
    always_comb begin
        wr_idx_next = wr_idx_reg;
        if (wr_start_in) begin
            wr_idx_next = 9'h000;
        end else if (wr_valid_in) begin
            wr_idx_next = 9'(wr_idx_reg + 9'h001);  // Wraps after 512 bytes
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_idx_reg <= 9'h000;
        end else begin
            wr_idx_reg <= wr_idx_next;
        end
    end

    // Plain memory, no reset: contents are defined once the host writes them
    always_ff @(posedge mclk_in) begin
        if (wr_valid_in && !wr_start_in) begin
            sel_mem[wr_idx_reg] <= wr_data_in;  // [RULE10] [RULE11]
        end
    end

    // ------------------------------------------------------------
    // Sector read path
    // ------------------------------------------------------------
    logic       rd_accept;
    logic       strm_busy;
    logic [8:0] rd_idx;
    logic [7:0] src_byte;
    logic [7:0] st_byte;
    logic [7:0] sel_byte;
    stl_log_e   log_reg;
    stl_log_e   log_next;
    stl_byte_s  strm_byte;

    // A start during a read is ignored; the log choice is held per read
    assign rd_accept = rd_start_in && !strm_busy;

    always_comb begin
        log_next = log_reg;
        if (rd_accept) begin
            log_next = rd_log_in;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            log_reg <= STL_LOG_SELFTEST;
        end else begin
            log_reg <= log_next;
        end
    end

    // Self-test log byte map
    always_comb begin
        logic [8:0] rel;
        logic [4:0] slot;
        logic [4:0] off;
        rel     = 9'(rd_idx - DESC_BASE);
        slot    = 5'(rel / DESC_BYTES);
        off     = 5'(rel % DESC_BYTES);
        st_byte = 8'h00;  // Reserved and vendor bytes read zero
        if (rd_idx < DESC_BASE) begin
            st_byte = pick_byte({48'h0, REVISION}, rd_idx[2:0] - REV_OFF[2:0]);  // [RULE1] [RULE8]
        end else if (rd_idx < 9'(DESC_BASE + 9'(SLOTS) * DESC_BYTES)) begin
            if (slot < 5'(SLOTS)) begin
                st_byte = desc_byte(slot_reg[slot], off);  // [RULE2]
            end
        end else if (rd_idx == PTR_OFF) begin
            st_byte = ptr_reg;  // [RULE6]
        end
    end

    // Selective log byte map: progress fields come live from the test engine
    always_comb begin
        logic [8:0] rel;
        rel      = 9'h000;
        sel_byte = sel_mem[rd_idx];  // [RULE10] [RULE12]
        if (rd_idx >= SEL_RSV_OFF && rd_idx < SEL_RSV_END) begin
            sel_byte = 8'h00;  // [RULE12]
        end else if (rd_idx >= SEL_LBA_OFF && rd_idx < SEL_SPAN_OFF) begin
            rel      = 9'(rd_idx - SEL_LBA_OFF);
            sel_byte = pick_byte(prog_lba_in, rel[2:0]);  // [RULE11] [RULE8]
        end else if (rd_idx >= SEL_SPAN_OFF && rd_idx < SEL_SPAN_END) begin
            rel      = 9'(rd_idx - SEL_SPAN_OFF);
            sel_byte = pick_byte({48'h0, prog_span_in}, rel[2:0]);  // [RULE11]
        end
    end

    assign src_byte = (log_reg == STL_LOG_SELECTIVE) ? sel_byte : st_byte;

    // Streamer walks the byte map and closes with the checksum
    stl_sector_streamer u_streamer (
        .mclk_in     (mclk_in),
        .sys_rst_in  (sys_rst_in),
        .start_in    (rd_accept),
        .src_byte_in (src_byte),
        .src_idx_out (rd_idx),
        .byte_out    (strm_byte),
        .busy_out    (strm_busy)
    );

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign ptr_out      = ptr_reg;
    assign rd_valid_out = strm_byte.valid;
    assign rd_last_out  = strm_byte.last;
    assign rd_data_out  = strm_byte.data;
    assign busy_out     = strm_busy;

endmodule

// File: src/stl_sector_streamer.sv
// Streams one 512-byte sector and appends the closing checksum byte
`timescale 1ns/1ps
module stl_sector_streamer import stl_pkg::*; (
    input  wire logic       mclk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       start_in,
    input  wire logic [7:0] src_byte_in,
    output logic      [8:0] src_idx_out,
    output stl_byte_s       byte_out,
    output logic            busy_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    stl_state_e state_reg;
    stl_state_e state_next;
    logic [8:0] idx_reg;
    logic [8:0] idx_next;
    logic [7:0] sum_reg;
    logic [7:0] sum_next;
    stl_byte_s  out_reg;
    stl_byte_s  out_next;
    logic       busy_reg;
    logic       busy_next;

    // Walk bytes 0..510 from the source, then emit the negated sum
    always_comb begin
        state_next = state_reg;
        idx_next   = idx_reg;
        sum_next   = sum_reg;
        out_next   = '0;
        case (state_reg)
            STL_ST_IDLE: begin
                if (start_in) begin
                    state_next = STL_ST_STREAM;
                    idx_next   = 9'h000;
                    sum_next   = 8'h00;
                end
            end
            STL_ST_STREAM: begin
                out_next.valid = 1'b1;
                out_next.data  = src_byte_in;
                sum_next       = 8'(sum_reg + src_byte_in);  // [RULE9]
                idx_next       = 9'(idx_reg + 9'h001);
                if (idx_next == CSUM_OFF) begin
                    state_next = STL_ST_CSUM;
                end
            end
            STL_ST_CSUM: begin
                // Whole sector then sums to zero modulo 256
                out_next.valid = 1'b1;
                out_next.last  = 1'b1;
                out_next.data  = 8'(8'h00 - sum_reg);  // [RULE9]
                state_next     = STL_ST_IDLE;
            end
            default: begin
                state_next = STL_ST_IDLE;
            end
        endcase
        // Busy follows the state one edge ahead so it can leave a flip-flop
        busy_next = (state_next != STL_ST_IDLE);
    end

    // Registers only
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= STL_ST_IDLE;
            idx_reg   <= 9'h000;
            sum_reg   <= 8'h00;
            out_reg   <= '0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg   <= idx_next;
            sum_reg   <= sum_next;
            out_reg   <= out_next;
            busy_reg  <= busy_next;
        end
    end

    assign src_idx_out = idx_reg;
    assign byte_out    = out_reg;
    assign busy_out    = busy_reg;  // Registered, no decode glitch at the port

endmodule
